//--- cpu_interrupt_hold_control.sv
// Local bus control, interrupt, hold and coprocessor hand-off unit.
`timescale 1ns/1ps
// Notes on behaviour
// - A bus cycle of any kind completes only when ready is high.
// - While ready is low wait states repeat; ready sampled each one.
// - Ready stretches memory, I/O and internal cycles alike.
// - While interrupt request is low the level code is latched.
// - Grant when latched code is at most mask bits 12-15.
// - Code keeps being sampled while request stays low.
// - Four-bit code, first bit most significant, zero is highest.
// - NMI traps through FFFC after the current instruction.
// - NMI ends the idle state.
// - NMI at reset release runs after the reset trap.
// - NMI held two clocks; recognised once per falling edge.
// - Reset clears the status word and inhibits all strobes.
// - Reset release starts level 0 trap via 0000, status cleared.
// - Reset ends the idle state.
// - Hold request: show released code, then float the bus.
// - Hold released high ends the hold and processing resumes.
// - Status outputs show cycle kind; 000 is interlock; float in hold.
// - MID fetch drives MID status and samples coprocessor input.
// - Coprocessor low: level 2 switch, hold, restore on release.
// - No coprocessor: emulate; undefined opcode traps to level 2.
// - Latch strobe falls once with released code before floating.
module cpu_interrupt_hold_control
  import cpu_ctl_pkg::*;
#(
  parameter int SYNC_W = 9
)(
  // APB slave
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Asynchronous pins
  input  wire logic        ready,
  input  wire logic        interrupt_request_n,
  input  wire logic [3:0]  interrupt_level_code,
  input  wire logic        nonmaskable_irq_n,
  input  wire logic        hold_n,
  input  wire logic        coproc_present_n,
  // Core side
  input  wire logic        cycle_req,
  input  wire logic [1:0]  cycle_kind,
  input  wire logic        cycle_write,
  input  wire logic        mid_fetch,
  input  wire logic        instr_boundary,
  input  wire logic        emul_undefined,
  output logic             cycle_done,
  output logic             trap_req,
  output logic      [15:0] trap_vector,
  output logic      [3:0]  trap_level,
  output logic             ctx_restore,
  output logic             emul_start,
  output logic             idle_exit,
  // Local bus pins
  output logic             address_latch_strobe,
  output logic             memory_cycle_n,
  output logic             read_strobe_n,
  output logic             write_strobe_n,
  output logic      [2:0]  bus_cycle_status,
  output logic             bus_oe
);

  if (SYNC_W != 9)
  begin : g_bad_w
    $error("SYNC_W must be 9");
  end

  // ****************************************************************
  // Input synchronisers
  // ****************************************************************
  logic [SYNC_W-1:0] raw;
  logic [SYNC_W-1:0] s1_q;
  logic [SYNC_W-1:0] s2_q;
  logic [SYNC_W-1:0] s3_q;
  logic [SYNC_W-1:0] f_q;

  assign raw = {coproc_present_n, hold_n, nonmaskable_irq_n,
                interrupt_level_code, interrupt_request_n, ready};

  // Three stages per bit; a change counts once stages two and three agree.
  genvar gi;
  generate
    for (gi = 0; gi < SYNC_W; gi++)
    begin : g_sync
      always_ff @(posedge pclk or negedge presetn)
      begin
        if (!presetn)
        begin
          s1_q[gi] <= 1'b1;
          s2_q[gi] <= 1'b1;
          s3_q[gi] <= 1'b1;
          f_q[gi]  <= 1'b1;
        end
        else
        begin
          s1_q[gi] <= raw[gi];
          s2_q[gi] <= s1_q[gi];
          s3_q[gi] <= s2_q[gi];
          if (s2_q[gi] == s3_q[gi])
            f_q[gi] <= s3_q[gi];
        end
      end
    end
  endgenerate

  logic       rdy_s;
  logic       irq_n_s;
  logic [3:0] code_s;
  logic       nmi_n_s;
  logic       hold_n_s;
  logic       app_n_s;
  assign rdy_s    = f_q[0];
  assign irq_n_s  = f_q[1];
  assign code_s   = f_q[5:2];
  assign nmi_n_s  = f_q[6];
  assign hold_n_s = f_q[7];
  assign app_n_s  = f_q[8];

  // ****************************************************************
  // Status word, APB slave
  // ****************************************************************
  logic [15:0] status_word_q;
  logic [3:0]  irq_code_q;
  logic        nmi_pend_q;
  logic        reset_pend_q;
  logic        coproc_q;
  logic        apb_wr;
  logic        apb_setup;
  bus_state_t  state_q;
  bus_state_t  state_d;

  assign apb_wr    = psel && penable && pwrite;
  assign apb_setup = psel && !penable;
  assign pready    = 1'b1;

  // Reset clears the whole word, and the reset trap clears it again.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      status_word_q <= 16'h0000;
    else if (reset_pend_q)
      status_word_q <= 16'h0000;
    else if (apb_wr && paddr == OFS_STATUS)
      status_word_q <= pwdata[15:0];
  end

  // Read data is captured in the setup phase so that it comes from a flop.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (apb_setup)
    begin
      pslverr <= 1'b0;
      if (paddr == OFS_STATUS)
        prdata <= {16'h0000, status_word_q};
      else if (paddr == OFS_STATE)
        prdata <= {20'h00000, irq_code_q, 1'b0, state_q,
                   coproc_q, nmi_pend_q, reset_pend_q, !irq_n_s};
      else if (paddr == OFS_TRAP)
        prdata <= {12'h000, trap_level, trap_vector};
      else
      begin
        prdata  <= 32'h0000_0000;
        pslverr <= 1'b1;
      end
    end
  end

  // ****************************************************************
  // Interrupt and trap logic
  // ****************************************************************
  logic       nmi_prev_q;
  logic       nmi_fall;
  logic       grant;
  logic [3:0] mask;

  assign mask     = status_word_q[MASK_MSB:MASK_LSB];
  assign nmi_fall = nmi_prev_q && !nmi_n_s;
  // Grant once the latch holds the current code; lower code wins.
  assign grant    = !irq_n_s && irq_code_q == code_s &&
                    irq_code_q <= mask;

  // The code register follows the pins for as long as the request is low.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      irq_code_q <= 4'hf;
    else if (!irq_n_s)
      irq_code_q <= code_s;
  end

  // A falling edge arms one NMI; the set wins over the service clear.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      nmi_prev_q <= 1'b1;
      nmi_pend_q <= 1'b0;
    end
    else
    begin
      nmi_prev_q <= nmi_n_s;
      if (nmi_fall)
        nmi_pend_q <= 1'b1;
      else if (trap_req && trap_vector == VEC_NMI)
        nmi_pend_q <= 1'b0;
    end
  end

  // The reset trap is pending from release; nothing else may come first.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      reset_pend_q <= 1'b1;
    else
      reset_pend_q <= 1'b0;
  end

  // Trap selection: reset, then NMI, then level 2, then maskable at a boundary.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      trap_req    <= 1'b0;
      trap_vector <= VEC_RESET;
      trap_level  <= LVL_RESET;
    end
    else
    begin
      trap_req <= 1'b0;
      if (reset_pend_q)
      begin
        trap_req    <= 1'b1;
        trap_vector <= VEC_RESET;
        trap_level  <= LVL_RESET;
      end
      else if (nmi_pend_q && !trap_req && (instr_boundary ||
               trap_vector == VEC_RESET))
      begin
        // Straight after the reset trap, before its first instruction.
        trap_req    <= 1'b1;
        trap_vector <= VEC_NMI;
        trap_level  <= LVL_NMI;
      end
      else if (mid_fetch && !app_n_s)
      begin
        trap_req    <= 1'b1;
        trap_vector <= {12'h000, LVL_MID} << VEC_SHIFT;
        trap_level  <= LVL_MID;
      end
      else if (emul_undefined)
      begin
        trap_req    <= 1'b1;
        trap_vector <= {12'h000, LVL_MID} << VEC_SHIFT;
        trap_level  <= LVL_MID;
      end
      else if (grant && instr_boundary && !trap_req)
      begin
        trap_req    <= 1'b1;
        trap_vector <= {12'h000, irq_code_q} << VEC_SHIFT;
        trap_level  <= irq_code_q;
      end
    end
  end

  // Idle ends on an NMI edge or at the end of reset.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      idle_exit <= 1'b0;
    else
      idle_exit <= nmi_fall || reset_pend_q;
  end

  // ****************************************************************
  // Coprocessor hand-off
  // ****************************************************************
  // Without a coprocessor the opcode goes to the emulation store.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      coproc_q    <= 1'b0;
      emul_start  <= 1'b0;
      ctx_restore <= 1'b0;
    end
    else
    begin
      emul_start  <= mid_fetch && app_n_s;
      ctx_restore <= coproc_q && app_n_s && state_q == ST_HOLD;
      if (mid_fetch && !app_n_s)
        coproc_q <= 1'b1;
      else if (coproc_q && app_n_s && state_q == ST_HOLD)
        coproc_q <= 1'b0;
    end
  end

  // ****************************************************************
  // Local bus sequencer
  // ****************************************************************
  logic hold_want;
  assign hold_want = !hold_n_s || coproc_q;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ST_IDLE:
        if (hold_want)
          state_d = ST_HLD_ALE;
        else if (cycle_req || mid_fetch)
          state_d = ST_ADDR;
      ST_ADDR:
        state_d = ST_DATA;
      ST_DATA:
        if (rdy_s)
          state_d = ST_IDLE;
      ST_HLD_ALE:
        state_d = ST_HLD_FAL;
      ST_HLD_FAL:
        state_d = ST_HOLD;
      ST_HOLD:
        if (!hold_want)
          state_d = ST_IDLE;
      default:
        state_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_q <= ST_IDLE;
    else
      state_q <= state_d;
  end

  // Cycle attributes are held for the whole cycle.
  logic [1:0] kind_q;
  logic       write_q;
  logic       mid_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      kind_q  <= KIND_INTERNAL;
      write_q <= 1'b0;
      mid_q   <= 1'b0;
    end
    else if (state_q == ST_IDLE && state_d == ST_ADDR)
    begin
      kind_q  <= cycle_kind;
      write_q <= cycle_write;
      mid_q   <= mid_fetch;
    end
  end

  // Pin drive; read and write strobes rest high, and reset forces all strobes inactive.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      address_latch_strobe <= 1'b0;
      memory_cycle_n       <= 1'b1;
      read_strobe_n        <= 1'b1;
      write_strobe_n       <= 1'b1;
      bus_cycle_status     <= BST_INTERNAL;
      bus_oe               <= 1'b1;
      cycle_done           <= 1'b0;
    end
    else
    begin
      cycle_done           <= state_q == ST_DATA && rdy_s;
      address_latch_strobe <= state_d == ST_ADDR ||
                              state_d == ST_HLD_ALE;
      bus_oe               <= state_d != ST_HOLD;
      memory_cycle_n       <= !((state_d == ST_ADDR ||
                                 state_d == ST_DATA) &&
                                kind_q == KIND_MEM &&
                                state_q != ST_IDLE ||
                                state_d == ST_ADDR &&
                                cycle_kind == KIND_MEM);
      read_strobe_n        <= !(state_d == ST_DATA && !write_q);
      write_strobe_n       <= !(state_d == ST_DATA && write_q);
      if (state_d == ST_HLD_ALE)
        bus_cycle_status <= BST_RELEASED;
      else if (state_d == ST_ADDR)
      begin
        if (mid_fetch)
          bus_cycle_status <= BST_MID;
        else if (cycle_kind == KIND_MEM)
          bus_cycle_status <= BST_MEMORY;
        else if (cycle_kind == KIND_IO)
          bus_cycle_status <= BST_IO;
        else if (cycle_kind == KIND_INTERLOCK)
          bus_cycle_status <= BST_INTERLOCK;
        else
          bus_cycle_status <= BST_INTERNAL;
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_READY_GATES: assert property (
    cycle_done |-> $past(state_q) == ST_DATA && $past(rdy_s))
    else $error("cycle done without ready");
  AST_WAIT_HOLDS: assert property (
    state_q == ST_DATA && !rdy_s |=> state_q == ST_DATA)
    else $error("wait state not inserted");
  AST_ALL_KINDS_WAIT: assert property (
    state_q == ST_DATA && kind_q != KIND_MEM && !rdy_s
    |=> !cycle_done)
    else $error("non-memory cycle ignored ready");
  AST_CODE_LATCH: assert property (
    !irq_n_s |=> irq_code_q == $past(code_s))
    else $error("code not latched");
  AST_MASKED: assert property (
    trap_req && trap_level > LVL_MID && trap_vector != VEC_NMI
    |-> $past(irq_code_q) <= $past(mask))
    else $error("masked level granted");
  AST_NMI_VEC: assert property (
    nmi_fall ##1 !reset_pend_q [*2] |-> ##[0:20] nmi_pend_q == 1'b1)
    else $error("nmi edge lost");
  AST_NMI_ONCE: assert property (
    trap_req && trap_vector == VEC_NMI |=> !nmi_pend_q || nmi_fall
    || $past(nmi_fall))
    else $error("nmi served twice");
  AST_RESET_TRAP: assert property (
    $rose(reset_pend_q) == 1'b0 && $fell(reset_pend_q)
    |-> trap_req && trap_vector == VEC_RESET && status_word_q == 16'h0)
    else $error("reset trap missing");
  AST_HOLD_SEQ: assert property (
    state_q == ST_IDLE && hold_want |=> bus_cycle_status == BST_RELEASED
    && address_latch_strobe ##1 !address_latch_strobe && bus_oe
    ##1 !bus_oe)
    else $error("hold entry sequence wrong");
  AST_HOLD_EXIT: assert property (
    state_q == ST_HOLD && !hold_want |=> state_q == ST_IDLE ##1 bus_oe)
    else $error("hold not released");
  AST_EMUL: assert property (
    mid_fetch && app_n_s |=> emul_start)
    else $error("emulation not started");

  COV_WAIT: cover property (state_q == ST_DATA && !rdy_s ##1 cycle_done);
  COV_HOLD: cover property (state_q == ST_HOLD ##1 state_q == ST_IDLE);
  COV_NMI:  cover property (trap_req && trap_vector == VEC_NMI);
  COV_IRQ:  cover property (trap_req && trap_level > LVL_MID);

endmodule : cpu_interrupt_hold_control

//--- cpu_ctl_pkg.sv
// Constants and types shared by the processor control unit.
package cpu_ctl_pkg;

  // ****************************************************************
  // Bus status codes driven on the three status outputs
  // ****************************************************************
  localparam logic [2:0] BST_INTERLOCK = 3'h0;
  localparam logic [2:0] BST_MEMORY    = 3'h4;
  localparam logic [2:0] BST_IO        = 3'h2;
  localparam logic [2:0] BST_INTERNAL  = 3'h3;
  localparam logic [2:0] BST_MID       = 3'h6;
  localparam logic [2:0] BST_RELEASED  = 3'h5;

  // ****************************************************************
  // Trap vectors, levels and status word layout
  // ****************************************************************
  localparam logic [15:0] VEC_RESET  = 16'h0000;
  localparam logic [15:0] VEC_NMI    = 16'hfffc;
  localparam logic [3:0]  LVL_RESET  = 4'h0;
  localparam logic [3:0]  LVL_MID    = 4'h2;
  localparam logic [3:0]  LVL_NMI    = 4'h0;
  localparam int          MASK_LSB   = 12;
  localparam int          MASK_MSB   = 15;
  localparam int          VEC_SHIFT  = 2;

  // ****************************************************************
  // Register offsets (byte addresses)
  // ****************************************************************
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_STATE  = 8'h04;
  localparam logic [7:0] OFS_TRAP   = 8'h08;

  // Kind of bus cycle that the core asks for.
  typedef enum logic [1:0] {
    KIND_MEM       = 2'b00,
    KIND_IO        = 2'b01,
    KIND_INTERNAL  = 2'b10,
    KIND_INTERLOCK = 2'b11
  } cycle_kind_t;

  // Local bus sequencer states.
  typedef enum logic [2:0] {
    ST_IDLE    = 3'b000,
    ST_ADDR    = 3'b001,
    ST_DATA    = 3'b010,
    ST_HLD_ALE = 3'b011,
    ST_HLD_FAL = 3'b100,
    ST_HOLD    = 3'b101
  } bus_state_t;

endpackage : cpu_ctl_pkg

//--- wait_state_partner.sv
// Wait-state logic on the far side of the local bus ready pin.
`timescale 1ns/1ps
module wait_state_partner (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Bus observation
  input  wire logic       address_latch_strobe,
  input  wire logic       cycle_done,
  input  wire logic       bus_oe,
  input  wire logic [3:0] wait_states,
  // Answer
  output logic            ready
);
  // ****************************************************************
  // Wait-state counter
  // ****************************************************************
  logic [3:0] cnt_q;
  logic       busy_q;

  // Counts wait states from the address phase. A stale ready would end
  // the next cycle early, so it drops when the cycle or the bus is gone.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q  <= 4'h0;
      busy_q <= 1'b0;
    end
    else if (address_latch_strobe && bus_oe)
    begin
      cnt_q  <= 4'h0;
      busy_q <= 1'b1;
    end
    else if (cycle_done || !bus_oe)
      busy_q <= 1'b0;
    else if (busy_q && cnt_q != wait_states)
      cnt_q <= cnt_q + 4'h1;
  end

  // Ready stays low until the chosen number of wait states has passed.
  assign ready = busy_q && (cnt_q == wait_states);
endmodule : wait_state_partner

//--- cpu_interrupt_hold_control_test.sv
// Self-checking bench for the interrupt, hold and bus control unit.
`timescale 1ns/1ps
module cpu_interrupt_hold_control_test import cpu_ctl_pkg::*;;
  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  logic        pclk = 1'b0;
  logic        presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        ready, interrupt_request_n, nonmaskable_irq_n, hold_n;
  logic        coproc_present_n, cycle_req, cycle_write, mid_fetch;
  logic        instr_boundary, emul_undefined, cycle_done, trap_req;
  logic        ctx_restore, emul_start, idle_exit, bus_oe;
  logic        address_latch_strobe, memory_cycle_n;
  logic        read_strobe_n, write_strobe_n;
  logic [1:0]  cycle_kind;
  logic [2:0]  bus_cycle_status;
  logic [3:0]  interrupt_level_code, trap_level, wait_states;
  logic [15:0] trap_vector;
  logic [19:0] trap_q[$];
  int          fail_count = 0;
  int          compares = 0;
  int          idle_cnt = 0, emul_cnt = 0, rest_cnt = 0;
  int          l0, l6, lt, mark;

  // The clock toggles every 10 ns, a period of 20 ns.
  always #10 pclk = ~pclk;

  cpu_interrupt_hold_control dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .ready(ready),
    .interrupt_request_n(interrupt_request_n),
    .interrupt_level_code(interrupt_level_code),
    .nonmaskable_irq_n(nonmaskable_irq_n), .hold_n(hold_n),
    .coproc_present_n(coproc_present_n), .cycle_req(cycle_req),
    .cycle_kind(cycle_kind), .cycle_write(cycle_write),
    .mid_fetch(mid_fetch), .instr_boundary(instr_boundary),
    .emul_undefined(emul_undefined), .cycle_done(cycle_done),
    .trap_req(trap_req), .trap_vector(trap_vector),
    .trap_level(trap_level), .ctx_restore(ctx_restore),
    .emul_start(emul_start), .idle_exit(idle_exit),
    .address_latch_strobe(address_latch_strobe),
    .memory_cycle_n(memory_cycle_n), .read_strobe_n(read_strobe_n),
    .write_strobe_n(write_strobe_n),
    .bus_cycle_status(bus_cycle_status), .bus_oe(bus_oe));

  wait_state_partner wsp (
    .pclk(pclk), .presetn(presetn),
    .address_latch_strobe(address_latch_strobe),
    .cycle_done(cycle_done), .bus_oe(bus_oe),
    .wait_states(wait_states), .ready(ready));

  // Pulses last one cycle, so they are recorded once each edge settles.
  always @(posedge pclk)
  begin
    #1;
    if (trap_req === 1'b1)
      trap_q.push_back({trap_level, trap_vector});
    if (idle_exit === 1'b1)
      idle_cnt++;
    if (emul_start === 1'b1)
      emul_cnt++;
    if (ctx_restore === 1'b1)
      rest_cnt++;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic print_verdict;
    if (fail_count == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      fail_count++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic stall;
    fail_count++;
    print_verdict();
  endtask : stall

  task automatic tick;
    @(posedge pclk);
    #1;
  endtask : tick

  // Bounded wait for a level on one of the unit's outputs.
  task automatic wait_for(ref logic s, input logic v);
    int n = 0;
    while (s !== v && n < 40)
    begin
      tick();
      n++;
    end
    if (n == 40)
      stall();
  endtask : wait_for

  // One APB transfer; read data and error are taken when pready is high.
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    if (n == 20)
      stall();
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic expect_trap(input logic [15:0] vec, input logic [3:0] lvl);
    int n = 0;
    while (trap_q.size() == 0 && n < 40)
    begin
      tick();
      n++;
    end
    if (n == 40)
      stall();
    chk(trap_q.pop_front(), {lvl, vec});
  endtask : expect_trap

  task automatic no_trap;
    repeat (30) tick();
    chk(32'(trap_q.size()), 32'h0);
  endtask : no_trap

  // One bus cycle from idle; lat counts edges from request to done.
  task automatic bus_cyc(input logic [1:0] k, input logic w, m,
                         input logic [3:0] ws, input logic [2:0] st,
                         output int lat);
    @(posedge pclk);
    wait_states <= ws;
    repeat (6) @(posedge pclk);
    cycle_req   <= ~m;
    mid_fetch   <= m;
    cycle_kind  <= k;
    cycle_write <= w;
    @(posedge pclk);
    cycle_req <= 1'b0;
    mid_fetch <= 1'b0;
    tick();
    chk(address_latch_strobe, 1'b0);
    chk(bus_cycle_status, st);
    if (!m && k != 2'd3)
      chk(memory_cycle_n, k != 2'd0);
    if (!m && k < 2'd2)
      chk(w ? write_strobe_n : read_strobe_n, 1'b0);
    lat = 2;
    while (cycle_done !== 1'b1 && lat < 40)
    begin
      tick();
      lat++;
    end
    if (lat == 40)
      stall();
    chk({read_strobe_n, write_strobe_n}, 2'b11);
  endtask : bus_cyc

  task automatic do_reset(input logic nmi_n);
    @(posedge pclk);
    presetn           <= 1'b0;
    nonmaskable_irq_n <= nmi_n;
    repeat (3) tick();
    chk({read_strobe_n, write_strobe_n, memory_cycle_n}, 3'h7);
    mark = idle_cnt;
    trap_q.delete();
    @(posedge pclk);
    presetn <= 1'b1;
    expect_trap(VEC_RESET, LVL_RESET);
    repeat (3) tick();
    chk(32'(idle_cnt > mark), 32'h1);
  endtask : do_reset

  task automatic irq_off;
    @(posedge pclk);
    interrupt_request_n <= 1'b1;
    repeat (8) tick();
    trap_q.delete();
  endtask : irq_off

  task automatic irq_case(input logic [3:0] mask, code, input logic want);
    apb(1'b1, OFS_STATUS, {16'h0, mask, 12'h000});
    @(posedge pclk);
    interrupt_level_code <= code;
    interrupt_request_n  <= 1'b0;
    if (want)
      expect_trap({10'h000, code, 2'b00}, code);
    else
      no_trap();
    irq_off();
  endtask : irq_case

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic test_regs;
    apb(1'b1, OFS_STATUS, 32'h0000f0a5);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd, 32'h0000f0a5);
    apb(1'b0, 8'h0c, 32'h0);
    chk({31'h0, err}, 32'h1);
    do_reset(1'b1);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd, 32'h0);
  endtask : test_regs

  task automatic test_bus;
    bus_cyc(KIND_MEM, 1'b0, 1'b0, 4'h0, BST_MEMORY, l0);
    bus_cyc(KIND_MEM, 1'b1, 1'b0, 4'h6, BST_MEMORY, l6);
    chk(32'(l6 - l0), 32'h6);
    bus_cyc(KIND_IO, 1'b0, 1'b0, 4'h6, BST_IO, lt);
    chk(32'(lt), 32'(l6));
    bus_cyc(KIND_INTERNAL, 1'b0, 1'b0, 4'h6, BST_INTERNAL, lt);
    chk(32'(lt), 32'(l6));
    bus_cyc(KIND_INTERLOCK, 1'b0, 1'b0, 4'h0, BST_INTERLOCK, lt);
  endtask : test_bus

  task automatic test_irq;
    irq_case(4'h5, 4'h5, 1'b1);
    irq_case(4'h5, 4'h6, 1'b0);
    irq_case(4'hf, 4'hf, 1'b1);
    irq_case(4'h0, 4'h0, 1'b1);
    irq_case(4'h4, 4'h8, 1'b0);
    apb(1'b1, OFS_STATUS, 32'h00005000);
    @(posedge pclk);
    interrupt_level_code <= 4'h9;
    interrupt_request_n  <= 1'b0;
    no_trap();
    @(posedge pclk);
    interrupt_level_code <= 4'h3;
    expect_trap(16'h000c, 4'h3);
    irq_off();
    irq_case(4'h5, 4'h6, 1'b0);
    @(posedge pclk);
    interrupt_request_n <= 1'b0;
    apb(1'b1, OFS_STATUS, 32'h00006000);
    expect_trap(16'h0018, 4'h6);
    irq_off();
  endtask : test_irq

  task automatic test_nmi;
    mark = idle_cnt;
    @(posedge pclk);
    instr_boundary    <= 1'b0;
    nonmaskable_irq_n <= 1'b0;
    repeat (2) @(posedge pclk); // The pin filter needs two clocks.
    nonmaskable_irq_n <= 1'b1;
    no_trap();
    @(posedge pclk);
    instr_boundary <= 1'b1;
    expect_trap(VEC_NMI, LVL_NMI);
    chk(32'(idle_cnt > mark), 32'h1);
    @(posedge pclk);
    nonmaskable_irq_n <= 1'b0;
    expect_trap(VEC_NMI, LVL_NMI);
    no_trap();
    @(posedge pclk);
    nonmaskable_irq_n <= 1'b1;
  endtask : test_nmi

  task automatic test_hold;
    @(posedge pclk);
    hold_n <= 1'b0;
    wait_for(address_latch_strobe, 1'b1);
    chk({bus_oe, bus_cycle_status}, {1'b1, BST_RELEASED});
    tick();
    chk({address_latch_strobe, bus_cycle_status}, {1'b0, BST_RELEASED});
    tick();
    chk(bus_oe, 1'b0);
    @(posedge pclk);
    hold_n <= 1'b1;
    wait_for(bus_oe, 1'b1);
    bus_cyc(KIND_MEM, 1'b0, 1'b0, 4'h0, BST_MEMORY, lt);
    chk(32'(lt), 32'(l0));
  endtask : test_hold

  task automatic test_coproc;
    trap_q.delete();
    @(posedge pclk);
    coproc_present_n <= 1'b0;
    bus_cyc(KIND_MEM, 1'b0, 1'b1, 4'h0, BST_MID, lt);
    expect_trap({10'h000, LVL_MID, 2'b00}, LVL_MID);
    wait_for(bus_oe, 1'b0);
    mark = rest_cnt;
    @(posedge pclk);
    coproc_present_n <= 1'b1;
    wait_for(bus_oe, 1'b1);
    repeat (4) tick();
    chk(32'(rest_cnt - mark), 32'h1);
    mark = emul_cnt;
    bus_cyc(KIND_MEM, 1'b0, 1'b1, 4'h0, BST_MID, lt);
    repeat (4) tick();
    chk(32'(emul_cnt - mark), 32'h1);
    chk(32'(trap_q.size()), 32'h0);
    @(posedge pclk);
    emul_undefined <= 1'b1;
    @(posedge pclk);
    emul_undefined <= 1'b0;
    expect_trap({10'h000, LVL_MID, 2'b00}, LVL_MID);
  endtask : test_coproc

  task automatic test_nmi_reset;
    do_reset(1'b0);
    expect_trap(VEC_NMI, LVL_NMI);
    @(posedge pclk);
    nonmaskable_irq_n <= 1'b1;
  endtask : test_nmi_reset

  // Main sequence: every input gets a value at time zero.
  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite, cycle_req, cycle_write} = 5'h00;
    {mid_fetch, emul_undefined, cycle_kind, wait_states, paddr} = 16'h0;
    {interrupt_request_n, nonmaskable_irq_n, hold_n} = 3'h7;
    {coproc_present_n, instr_boundary, interrupt_level_code} = 6'h3f;
    pwdata = 32'h0;
    do_reset(1'b1);
    test_regs();
    test_bus();
    test_irq();
    test_nmi();
    test_hold();
    test_coproc();
    test_nmi_reset();
    print_verdict();
  end
endmodule : cpu_interrupt_hold_control_test
